/* File: verilog/msfg_guard.sv */
// Stall, thermal and direction guard for a three-phase predriver.
`timescale 1ns/1ps
`include "msfg_defs.svh"
// Summary of operation
// - Stalled Hall inputs force high sides off.
// - Stall time parameter, 154 s per uF.
// - Stop held 10us clears stall fault.
// - Zero duty held twice interval clears fault.
// - Power cycle resets fault to clear.
// - Grounded timing node holds logic reset.
// - Disabled stall protection also disables thermal.
// - Over-temperature forces high sides off.
// - Direction change inserts dead time, no overlap.
// - Equal Hall states turn all outputs off.
// - Duty input active low; high means zero.
module msfg_guard #(
	parameter int STALL_CYC = `MSFG_STALL_CYC_DEF,
	parameter int ZERO_CYC  = `MSFG_ZERO_CYC_DEF,
	parameter int STOP_CYC  = `MSFG_STOP_HOLD_CYC,
	parameter int DEAD_CYC  = `MSFG_DEAD_CYC,
	parameter int CHECK_MIN = 1
) (
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       timing_node_ok,
	input  wire logic       run_enable,
	input  wire logic       reverse,
	input  wire logic       pulse_duty_input_n,
	input  wire logic       analog_zero_duty,
	input  wire logic       stall_guard_enable,
	input  wire logic       over_temp,
	input  wire logic [2:0] hall,
	input  wire logic [2:0] high_cmd,
	input  wire logic [2:0] low_cmd,
	output logic            phase_a_high_drive,
	output logic            phase_b_high_drive,
	output logic            phase_c_high_drive,
	output logic            phase_a_low_drive,
	output logic            phase_b_low_drive,
	output logic            phase_c_low_drive,
	output logic            stall_fault
);
	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	// Refuses counts that the counters cannot serve.
	if (STALL_CYC < 1 || ZERO_CYC < 1 || STOP_CYC < 1 || DEAD_CYC < 1) begin : g_bad_count
		$error("msfg_guard: timing parameter out of range");
	end
	if (CHECK_MIN != 0 && STALL_CYC < `MSFG_STALL_CYC_MIN) begin : g_short_stall
		$error("msfg_guard: stall time below the least legal setting");
	end

	localparam int SW = $clog2(STALL_CYC + 1);
	localparam int ZW = $clog2(ZERO_CYC + 1);
	localparam int TW = $clog2(STOP_CYC + 1);
	localparam int DW = $clog2(DEAD_CYC + 1);

	// ------------------------------------------------------------
	// Hall watcher
	// ------------------------------------------------------------
	msfg_hall_if hif ();
	assign hif.hall = hall;
	msfg_hall_watch u_watch (
		.core_clk (core_clk),
		.nrst     (nrst),
		.hw       (hif.watcher)
	);

	// ------------------------------------------------------------
	// Fault and timer state
	// ------------------------------------------------------------
	logic [SW-1:0] stall_cnt_r, stall_cnt_nxt;
	logic [ZW-1:0] zero_cnt_r, zero_cnt_nxt;
	logic [TW-1:0] stop_cnt_r, stop_cnt_nxt;
	logic          fault_r, fault_nxt;
	logic          zero_duty;
	logic          drive_mode;
	logic          release_req;

	assign drive_mode = run_enable && timing_node_ok;
	assign zero_duty  = pulse_duty_input_n || analog_zero_duty;
	assign release_req = (stop_cnt_r == TW'(STOP_CYC)) || (zero_cnt_r == ZW'(ZERO_CYC));

	// Next values of the stall timer, release timers and sticky fault.
	always_comb begin
		stall_cnt_nxt = stall_cnt_r;
		zero_cnt_nxt  = zero_cnt_r;
		stop_cnt_nxt  = stop_cnt_r;
		fault_nxt     = fault_r;
		if (!run_enable) begin
			if (stop_cnt_r != TW'(STOP_CYC))
				stop_cnt_nxt = stop_cnt_r + TW'(1);
		end else begin
			stop_cnt_nxt = '0;
		end
		if (zero_duty) begin
			if (zero_cnt_r != ZW'(ZERO_CYC))
				zero_cnt_nxt = zero_cnt_r + ZW'(1);
		end else begin
			zero_cnt_nxt = '0;
		end
		if (!drive_mode || !stall_guard_enable || hif.hall_edge || fault_r) begin
			stall_cnt_nxt = '0;
		end else if (stall_cnt_r != SW'(STALL_CYC)) begin
			stall_cnt_nxt = stall_cnt_r + SW'(1);
		end
		if (release_req || !timing_node_ok)
			fault_nxt = 1'b0;
		if (drive_mode && stall_guard_enable && !hif.hall_edge && stall_cnt_r == SW'(STALL_CYC))
			fault_nxt = 1'b1;
	end

	// Registers the timers and fault.
	// power-on clear
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stall_cnt_r <= '0;
			zero_cnt_r  <= '0;
			stop_cnt_r  <= '0;
			fault_r     <= 1'b0;
		end else begin
			stall_cnt_r <= stall_cnt_nxt;
			zero_cnt_r  <= zero_cnt_nxt;
			stop_cnt_r  <= stop_cnt_nxt;
			fault_r     <= fault_nxt;
		end
	end

	// ------------------------------------------------------------
	// Direction change dead time
	// ------------------------------------------------------------
	msfg_pkg::msfg_dir_t dir_st_r, dir_st_nxt;
	logic [DW-1:0] dead_cnt_r, dead_cnt_nxt;
	logic          dir_r, dir_nxt;

	always_comb begin
		dir_st_nxt   = dir_st_r;
		dead_cnt_nxt = dead_cnt_r;
		dir_nxt      = dir_r;
		unique case (dir_st_r)
			msfg_pkg::MSFG_RUN: begin
				if (reverse != dir_r) begin
					dir_st_nxt   = msfg_pkg::MSFG_DEAD;
					dead_cnt_nxt = '0;
				end
			end
			msfg_pkg::MSFG_DEAD: begin
				if (dead_cnt_r == DW'(DEAD_CYC - 1)) begin
					dir_st_nxt = msfg_pkg::MSFG_RUN;
					dir_nxt    = reverse;
				end else begin
					dead_cnt_nxt = dead_cnt_r + DW'(1);
				end
			end
		endcase
	end

	// Registers the direction sequencer.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dir_st_r   <= msfg_pkg::MSFG_RUN;
			dead_cnt_r <= '0;
			dir_r      <= 1'b0;
		end else begin
			dir_st_r   <= dir_st_nxt;
			dead_cnt_r <= dead_cnt_nxt;
			dir_r      <= dir_nxt;
		end
	end

	// ------------------------------------------------------------
	// Output gating
	// ------------------------------------------------------------
	logic [2:0] hi_nxt, lo_nxt, hi_r, lo_r;
	logic       all_off, hi_off;

	assign all_off = !drive_mode || hif.hall_invalid || (dir_st_r == msfg_pkg::MSFG_DEAD);
	// thermal gate, disabled with stall guard
	assign hi_off  = fault_r || (over_temp && stall_guard_enable) || zero_duty;

	// Computes gated drives; low sides never share a phase with high.
	always_comb begin
		hi_nxt = (all_off || hi_off) ? 3'h0 : high_cmd;
		lo_nxt = all_off ? 3'h0 : (low_cmd & ~high_cmd);
	end

	// Registers the six drive outputs.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hi_r <= 3'h0;
			lo_r <= 3'h0;
		end else begin
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
		end
	end

	assign phase_a_high_drive = hi_r[0];
	assign phase_b_high_drive = hi_r[1];
	assign phase_c_high_drive = hi_r[2];
	assign phase_a_low_drive  = lo_r[0];
	assign phase_b_low_drive  = lo_r[1];
	assign phase_c_low_drive  = lo_r[2];
	assign stall_fault        = fault_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	stall_latch_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(drive_mode && stall_guard_enable && !hif.hall_edge && stall_cnt_r == SW'(STALL_CYC)) |=> fault_r)
		else $error("stall fault not latched");
	fault_gates_high_a: assert property (@(posedge core_clk) disable iff (!nrst)
		fault_r |=> (hi_r == 3'h0))
		else $error("high side on during fault");
	stop_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(stop_cnt_r == TW'(STOP_CYC) && fault_r) |=> !fault_r)
		else $error("stop hold did not release fault");
	zero_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(zero_cnt_r == ZW'(ZERO_CYC) && fault_r && stall_cnt_r == SW'(0)) |=> !fault_r)
		else $error("zero duty hold did not release fault");
	node_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!timing_node_ok |=> (hi_r == 3'h0 && lo_r == 3'h0 && !fault_r))
		else $error("drive while timing node grounded");
	no_guard_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(!stall_guard_enable && !fault_r) |=> !fault_r)
		else $error("stall fault while protection disabled");
	thermal_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(over_temp && stall_guard_enable) |=> (hi_r == 3'h0))
		else $error("high side on during over-temperature");
	dead_time_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(dir_st_r == msfg_pkg::MSFG_RUN && reverse != dir_r) |=> ##1 (hi_r == 3'h0 && lo_r == 3'h0))
		else $error("no dead time on reversal");
	hall_equal_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(hall == 3'h7 || hall == 3'h0) |=> (hi_r == 3'h0 && lo_r == 3'h0))
		else $error("outputs on with invalid hall pattern");
	no_shoot_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(hi_r & lo_r) == 3'h0)
		else $error("both switches of one phase on");
	stall_cov: cover property (@(posedge core_clk) disable iff (!nrst) $rose(fault_r));
	release_cov: cover property (@(posedge core_clk) disable iff (!nrst) $fell(fault_r));
	reverse_cov: cover property (@(posedge core_clk) disable iff (!nrst) dir_st_r == msfg_pkg::MSFG_DEAD);
endmodule : msfg_guard

/* File: verilog/msfg_defs.svh */
// Timing constants for the motor stall fault guard.
`ifndef MSFG_DEFS_SVH
`define MSFG_DEFS_SVH
// ------------------------------------------------------------
// Clock and time base
// ------------------------------------------------------------
`define MSFG_CLK_HZ            20000000
// Stall time in milliseconds per microfarad of timing capacitance.
`define MSFG_STALL_MS_PER_UF   154000
// Release interval in milliseconds per microfarad (one interval).
`define MSFG_REL_MS_PER_UF     500
// Default timing capacitance in nanofarads.
`define MSFG_DEF_CAP_NF        10
// Least capacitance the integrator may select, in picofarads.
`define MSFG_MIN_CAP_PF        4700
// Stop hold time in nanoseconds.
`define MSFG_STOP_HOLD_NS      10000
// Dead time inserted on direction change, in nanoseconds.
`define MSFG_DEAD_NS           2000
`define MSFG_STOP_HOLD_CYC     ((`MSFG_STOP_HOLD_NS * 20 + 999) / 1000)
`define MSFG_DEAD_CYC          ((`MSFG_DEAD_NS * 20 + 999) / 1000)
// Stall limit for the default capacitor: 1.54 s at 20 MHz.
`define MSFG_STALL_CYC_DEF     (`MSFG_STALL_MS_PER_UF * `MSFG_DEF_CAP_NF / 1000 * (`MSFG_CLK_HZ / 1000))
// Zero-duty hold: twice the release interval, 10 ms at 20 MHz.
`define MSFG_ZERO_CYC_DEF      (2 * `MSFG_REL_MS_PER_UF * `MSFG_DEF_CAP_NF * (`MSFG_CLK_HZ / 1000) / 1000)
// Least stall limit, from the smallest legal capacitance.
`define MSFG_STALL_CYC_MIN     (`MSFG_STALL_MS_PER_UF / 1000 * `MSFG_MIN_CAP_PF * (`MSFG_CLK_HZ / 1000000))
`endif

/* File: verilog/msfg_pkg.sv */
// Types shared by the motor stall fault guard modules.
package msfg_pkg;
	// Commutation state while handling a direction change.
	typedef enum logic [1:0] {
		MSFG_RUN,
		MSFG_DEAD
	} msfg_dir_t;
endpackage : msfg_pkg

/* File: verilog/msfg_hall_if.sv */
// Interface carrying Hall state between the main block and the watcher.
`timescale 1ns/1ps
interface msfg_hall_if;
	logic [2:0] hall;
	logic       hall_edge;
	logic       hall_invalid;
	modport watcher (input hall, output hall_edge, output hall_invalid);
	modport user    (output hall, input hall_edge, input hall_invalid);
endinterface : msfg_hall_if

/* File: verilog/msfg_hall_watch.sv */
// Hall edge detector and all-equal pattern check.
`timescale 1ns/1ps
module msfg_hall_watch (
	input  wire logic     core_clk,
	input  wire logic     nrst,
	msfg_hall_if.watcher  hw
);
	logic [2:0] hall_prev_r;
	logic [2:0] hall_prev_nxt;

	// Next value of the last sampled Hall pattern.
	always_comb begin
		hall_prev_nxt = hw.hall;
	end

	// Registers the previous Hall pattern.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hall_prev_r <= 3'h0;
		end else begin
			hall_prev_r <= hall_prev_nxt;
		end
	end

	assign hw.hall_edge    = (hw.hall != hall_prev_r);
	assign hw.hall_invalid = (hw.hall == 3'h0) || (hw.hall == 3'h7);
endmodule : msfg_hall_watch

/* File: dv/msfg_motor_model.sv */
// Motor model: Hall sensor rotation and power stage overlap watch.
`timescale 1ns/1ps
module msfg_motor_model (
	input  wire logic       core_clk,
	input  wire logic       spin,
	input  wire logic [2:0] high_drv,
	input  wire logic [2:0] low_drv,
	output logic [2:0]      hall,
	output int              overlap_cnt
);
	logic [2:0] step_cnt = 3'h0;
	int         pos = 0;
	int         ovl_r = 0;
	logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	assign hall = seq[pos];
	assign overlap_cnt = ovl_r;
	// ------------------------------------------------------------
	// Rotor and transistor pair watch
	// ------------------------------------------------------------
	// The rotor steps one Hall state every eight clocks while it spins.
	always @(posedge core_clk) begin
		step_cnt <= step_cnt + 3'h1;
		if (spin && step_cnt == 3'h7)
			pos <= (pos + 1) % 6;
		if ((high_drv & low_drv) != 3'h0)
			ovl_r <= ovl_r + 1;
	end
endmodule : msfg_motor_model

/* File: dv/msfg_guard_bench.sv */
// Self-checking bench for the motor stall fault guard.
`timescale 1ns/1ps
module msfg_guard_bench;
	localparam int DEAD = 4;
	logic       core_clk = 1'b0;
	logic       nrst, node_ok, run, rev, duty_n, azero, guard, hot, spin, bad;
	logic       ah, bh, ch, al, bl, cl, flt;
	logic [2:0] hi_cmd, lo_cmd, m_hall, hall;
	wire  [6:0] obs;
	int         fail_count, check_count, ovl, k;
	assign hall = bad ? 3'h7 : m_hall;
	assign obs = {ch, bh, ah, cl, bl, al, flt};
	always #25 core_clk = ~core_clk;
	msfg_guard #(.STALL_CYC(50), .ZERO_CYC(20), .STOP_CYC(10), .DEAD_CYC(DEAD), .CHECK_MIN(0)) msfg_guard_inst (
		.core_clk(core_clk), .nrst(nrst), .timing_node_ok(node_ok), .run_enable(run), .reverse(rev),
		.pulse_duty_input_n(duty_n), .analog_zero_duty(azero), .stall_guard_enable(guard),
		.over_temp(hot), .hall(hall), .high_cmd(hi_cmd), .low_cmd(lo_cmd),
		.phase_a_high_drive(ah), .phase_b_high_drive(bh), .phase_c_high_drive(ch),
		.phase_a_low_drive(al), .phase_b_low_drive(bl), .phase_c_low_drive(cl), .stall_fault(flt));
	msfg_motor_model msfg_motor_model_inst (.core_clk(core_clk), .spin(spin), .high_drv({ch, bh, ah}),
		.low_drv({cl, bl, al}), .hall(m_hall), .overlap_cnt(ovl));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// Waits n rising edges so the caller drives on an edge.
	task go(input int n);
		repeat (n) @(posedge core_clk);
	endtask : go
	// Compares all seven outputs at the falling edge.
	task chk(input string what, input logic [6:0] exp);
		@(negedge core_clk);
		check_count++;
		if (obs !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, obs);
		end
	endtask : chk
	// Compares a count kept by the model.
	task chk_cnt(input string what, input int exp, input int got);
		check_count++;
		if (got != exp) begin
			fail_count++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_cnt
	// Waits a bounded time for the fault flag to reach v.
	task wait_flt(input logic v);
		int i;
		for (i = 0; i < 300 && flt !== v; i++)
			@(negedge core_clk);
		if (flt !== v) begin
			fail_count++;
			$display("mismatch fault wait expected %b seen %b", v, flt);
			tally_and_finish();
		end
	endtask : wait_flt
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	// Runs each test in turn and closes with the verdict.
	initial begin
		{nrst, rev, run, azero, hot, spin, bad} = 7'h00;
		{node_ok, duty_n, guard} = 3'h7;
		{hi_cmd, lo_cmd} = 6'h00;
		fail_count = 0;
		check_count = 0;
		go(3);
		nrst <= 1'b1;
		chk("reset", 7'h00);
		go(1);
		{run, spin} <= 2'h3;
		duty_n <= 1'b0;
		hi_cmd <= 3'h1;
		lo_cmd <= 3'h3;
		go(3);
		chk("drive", 7'h14);
		go(1);
		spin <= 1'b0;
		go(40);
		chk("early", 7'h14);
		wait_flt(1'b1);
		chk("stall", 7'h05);
		$display("test stall done");
		go(1);
		run <= 1'b0;
		go(7);
		chk("stop short", 7'h01);
		wait_flt(1'b0);
		chk("stop release", 7'h00);
		go(1);
		{run, spin} <= 2'h3;
		for (k = 0; k < 2; k++) begin
			go(20);
			spin <= 1'b0;
			wait_flt(1'b1);
			go(1);
			if (k == 0)
				duty_n <= 1'b1;
			else
				azero <= 1'b1;
			go(3);
			chk("zero duty", 7'h05);
			wait_flt(1'b0);
			chk("zero release", 7'h04);
			go(1);
			{duty_n, azero} <= 2'h0;
			spin <= 1'b1;
		end
		$display("test release done");
		go(3);
		hot <= 1'b1;
		go(3);
		chk("thermal", 7'h04);
		go(1);
		{guard, spin} <= 2'h0;
		go(80);
		chk("guard off", 7'h14);
		go(1);
		{hot, guard, spin} <= 3'h3;
		go(3);
		bad <= 1'b1;
		go(3);
		chk("hall equal", 7'h00);
		go(1);
		bad <= 1'b0;
		spin <= 1'b0;
		go(3);
		// Reversal only once the rotor has slowed.
		rev <= 1'b1;
		go(2);
		chk("dead time", 7'h00);
		go(DEAD + 3);
		chk("new dir", 7'h14);
		$display("test protect done");
		wait_flt(1'b1);
		go(1);
		node_ok <= 1'b0;
		go(2);
		chk("node low", 7'h00);
		go(1);
		node_ok <= 1'b1;
		wait_flt(1'b1);
		go(1);
		nrst <= 1'b0;
		go(3);
		nrst <= 1'b1;
		chk("power cycle", 7'h00);
		chk_cnt("overlap", 0, ovl);
		$display("test reset done");
		tally_and_finish();
	end
endmodule : msfg_guard_bench
